/* File: src/pio_pkg.sv */
/*
  constants, register map and helper functions for the parallel port block.
  assumes a 32-bit axi4-lite register bus with word-aligned registers.
*/
package pio_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_PORT_A_DATA = 4'h0;
  localparam logic [3:0] IDX_PORT_B_DATA = 4'h1;
  localparam logic [3:0] IDX_PORT_C_DATA = 4'h2;
  localparam logic [3:0] IDX_PORT_D_SAMPLE = 4'h3;
  localparam logic [3:0] IDX_PORT_A_DIR = 4'h4;
  localparam logic [3:0] IDX_PORT_B_DIR = 4'h5;
  localparam logic [3:0] IDX_PORT_C_DIR = 4'h6;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;
  localparam int PD_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and response codes
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // port d read layout
  localparam int PD_BIT_GP = 7;
  localparam int PD_BIT_UNUSED = 6;
  localparam int PD_SPI_HI = 5;
  localparam int PD_SPI_LO = 2;
  localparam int PD_SCI_HI = 1;
  localparam int PD_SCI_LO = 0;

  typedef enum logic [2:0] {
    PIO_REG_A_DATA,
    PIO_REG_B_DATA,
    PIO_REG_C_DATA,
    PIO_REG_D_SAMPLE,
    PIO_REG_A_DIR,
    PIO_REG_B_DIR,
    PIO_REG_C_DIR,
    PIO_REG_NONE
  } pio_reg_type;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths
  function automatic pio_reg_type pio_decode(input logic [ADDR_W-1:0] addr);
    pio_reg_type sel;
    sel = PIO_REG_NONE;
    if (addr[ADDR_W-1:6] != '0 || addr[1:0] != 2'h0) begin
      sel = PIO_REG_NONE;
    end else if (addr[5:2] == IDX_PORT_A_DATA) begin
      sel = PIO_REG_A_DATA;
    end else if (addr[5:2] == IDX_PORT_B_DATA) begin
      sel = PIO_REG_B_DATA;
    end else if (addr[5:2] == IDX_PORT_C_DATA) begin
      sel = PIO_REG_C_DATA;
    end else if (addr[5:2] == IDX_PORT_D_SAMPLE) begin
      sel = PIO_REG_D_SAMPLE;
    end else if (addr[5:2] == IDX_PORT_A_DIR) begin
      sel = PIO_REG_A_DIR;
    end else if (addr[5:2] == IDX_PORT_B_DIR) begin
      sel = PIO_REG_B_DIR;
    end else if (addr[5:2] == IDX_PORT_C_DIR) begin
      sel = PIO_REG_C_DIR;
    end
    return sel;
  endfunction

  // per bit: outputs read the latch, inputs read the pin
  function automatic logic [7:0] pio_port_read(input logic [7:0] dir,
      input logic [7:0] latch, input logic [7:0] pin);
    return (dir & latch) | (~dir & pin);
  endfunction

endpackage

/* File: src/pio_sync.sv */
/*
  two-flop synchroniser for pin levels.
  assumes pins may change at any time relative to sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module pio_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pio_sync

`default_nettype wire

/* File: src/pio_ports.sv */
/*
  parallel port block: three bidirectional 8-bit ports and one 7-bit
  input-only port behind an axi4-lite slave.
  assumes synchronous bus signals, pins sampled through synchronisers,
  and serial enables supplied by the serial modules.
*/
// Local design decision: register access over AXI4-Lite.
// Behaviour
// - ports a, b, c each have 8-bit latch, reset keeps it
// - direction 1 drives pin, 0 floats it
// - reset clears port b direction
// - reset clears port c direction
// - port b output direction disables its pull-up
// - output pin driven from its latch bit
// - output pin reads back latch value
// - input pin reads back pin level
// - latch writes accepted in any direction, stored only when strobe bit 0 is set
// - port d input only, reads pins
// - spi enabled reads port d 5:2 zero
// - sci enabled reads port d 1:0 zero
// - port d layout gp, unused, serial pins
// - port c direction 8 bits, reset zero
// - port a matches ports b and c
`timescale 1ns/100ps
`default_nettype none

module pio_ports (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [pio_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pio_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [pio_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pio_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bidirectional pins
  input wire logic [7:0] first_port_pins_in,
  output logic [7:0] first_port_pins_out,
  output logic [7:0] first_port_pins_oe,
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe,
  output logic [7:0] second_port_pullup_en,
  input wire logic [7:0] third_port_pins_in,
  output logic [7:0] third_port_pins_out,
  output logic [7:0] third_port_pins_oe,
  // input-only port and sharing controls
  input wire logic [pio_pkg::PD_W-1:0] input_port_pins_in,
  input wire logic spi_enabled,
  input wire logic sci_enabled,
  input wire logic pullup_option
);

  logic [7:0] pa_latch_r;
  logic [7:0] pb_latch_r;
  logic [7:0] pc_latch_r;
  logic [7:0] port_a_direction_r;
  logic [7:0] port_b_direction_r;
  logic [7:0] port_c_direction_r;
  logic [7:0] pa_sync;
  logic [7:0] pb_sync;
  logic [7:0] pc_sync;
  logic [pio_pkg::PD_W-1:0] pd_sync;
  logic aw_held_r;
  logic w_held_r;
  logic [pio_pkg::ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic wr_go;
  pio_pkg::pio_reg_type wr_sel;
  pio_pkg::pio_reg_type rd_sel;
  logic [7:0] rd_nxt;
  logic [7:0] pd_view;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  pio_sync #(
    .WIDTH(3 * pio_pkg::PORT_W + pio_pkg::PD_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .async_in({first_port_pins_in, second_port_pins_in, third_port_pins_in,
      input_port_pins_in}),
    .sync_out({pa_sync, pb_sync, pc_sync, pd_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_sel = pio_pkg::pio_decode(aw_addr_r);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      s_axi_awready <= 1'b1;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end else if (!aw_held_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_strb_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end else if (!w_held_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pio_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == pio_pkg::PIO_REG_NONE) ?
          pio_pkg::RESP_SLVERR : pio_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data latches, no reset
  always_ff @(posedge sys_clk) begin
    if (ce && wr_go && w_strb_r) begin
      if (wr_sel == pio_pkg::PIO_REG_A_DATA) begin
        pa_latch_r <= w_data_r;
      end
      if (wr_sel == pio_pkg::PIO_REG_B_DATA) begin
        pb_latch_r <= w_data_r;
      end
      if (wr_sel == pio_pkg::PIO_REG_C_DATA) begin
        pc_latch_r <= w_data_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction registers; port d selects store nothing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      port_a_direction_r <= pio_pkg::DIR_RESET;
      port_b_direction_r <= pio_pkg::DIR_RESET;
      port_c_direction_r <= pio_pkg::DIR_RESET;
    end else if (ce && wr_go && w_strb_r) begin
      if (wr_sel == pio_pkg::PIO_REG_A_DIR) begin
        port_a_direction_r <= w_data_r;
      end
      if (wr_sel == pio_pkg::PIO_REG_B_DIR) begin
        port_b_direction_r <= w_data_r;
      end
      if (wr_sel == pio_pkg::PIO_REG_C_DIR) begin
        port_c_direction_r <= w_data_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  assign first_port_pins_out = pa_latch_r;
  assign second_port_pins_out = pb_latch_r;
  assign third_port_pins_out = pc_latch_r;
  assign first_port_pins_oe = port_a_direction_r;
  assign second_port_pins_oe = port_b_direction_r;
  assign third_port_pins_oe = port_c_direction_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      second_port_pullup_en <= '0;
    end else if (ce) begin
      second_port_pullup_en <= {8{pullup_option}} & ~port_b_direction_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  assign rd_sel = pio_pkg::pio_decode(s_axi_araddr);

  always_comb begin
    pd_view = 8'h00;
    pd_view[pio_pkg::PD_BIT_GP] = pd_sync[pio_pkg::PD_W-1];
    pd_view[pio_pkg::PD_BIT_UNUSED] = 1'b0;
    pd_view[pio_pkg::PD_SPI_HI:pio_pkg::PD_SPI_LO] = spi_enabled ? 4'h0 :
      pd_sync[pio_pkg::PD_SPI_HI:pio_pkg::PD_SPI_LO];
    pd_view[pio_pkg::PD_SCI_HI:pio_pkg::PD_SCI_LO] = sci_enabled ? 2'h0 :
      pd_sync[pio_pkg::PD_SCI_HI:pio_pkg::PD_SCI_LO];
  end

  always_comb begin
    rd_nxt = 8'h00;
    case (rd_sel)
      pio_pkg::PIO_REG_A_DATA: begin
        rd_nxt = pio_pkg::pio_port_read(port_a_direction_r, pa_latch_r, pa_sync);
      end
      pio_pkg::PIO_REG_B_DATA: begin
        rd_nxt = pio_pkg::pio_port_read(port_b_direction_r, pb_latch_r, pb_sync);
      end
      pio_pkg::PIO_REG_C_DATA: begin
        rd_nxt = pio_pkg::pio_port_read(port_c_direction_r, pc_latch_r, pc_sync);
      end
      pio_pkg::PIO_REG_D_SAMPLE: begin
        rd_nxt = pd_view;
      end
      pio_pkg::PIO_REG_A_DIR: begin
        rd_nxt = port_a_direction_r;
      end
      pio_pkg::PIO_REG_B_DIR: begin
        rd_nxt = port_b_direction_r;
      end
      pio_pkg::PIO_REG_C_DIR: begin
        rd_nxt = port_c_direction_r;
      end
      default: begin
        rd_nxt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= pio_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_nxt};
        s_axi_rresp <= (rd_sel == pio_pkg::PIO_REG_NONE) ?
          pio_pkg::RESP_SLVERR : pio_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ar_take(pio_pkg::pio_reg_type sel);
    ce && s_axi_arvalid && s_axi_arready && rd_sel == sel;
  endsequence

  sequence s_wr_commit(pio_pkg::pio_reg_type sel);
    ce && wr_go && w_strb_r && wr_sel == sel;
  endsequence

  a_dir_reset_clear: assert property (@(posedge sys_clk)
    $rose(resetn) |-> port_b_direction_r == pio_pkg::DIR_RESET
      && port_c_direction_r == pio_pkg::DIR_RESET && second_port_pins_oe == 8'h00)
    else $error("direction not cleared by reset");

  a_dir_write_oe: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_wr_commit(pio_pkg::PIO_REG_C_DIR) |=> third_port_pins_oe == $past(w_data_r))
    else $error("port c enable does not follow direction write");

  a_latch_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_wr_commit(pio_pkg::PIO_REG_B_DATA) |=> second_port_pins_out == $past(w_data_r))
    else $error("port b pin does not follow latch write");

  a_out_reads_latch: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ar_take(pio_pkg::PIO_REG_B_DATA) ##0 port_b_direction_r == 8'hFF
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(pb_latch_r))
    else $error("output pin read does not return latch");

  a_in_reads_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ar_take(pio_pkg::PIO_REG_C_DATA) ##0 port_c_direction_r == 8'h00
      |=> s_axi_rdata[7:0] == $past(pc_sync))
    else $error("input pin read does not return pin level");

  a_spi_mask_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ar_take(pio_pkg::PIO_REG_D_SAMPLE) ##0 spi_enabled
      |=> s_axi_rdata[pio_pkg::PD_SPI_HI:pio_pkg::PD_SPI_LO] == 4'h0)
    else $error("spi shared bits not zero");

  a_sci_mask_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ar_take(pio_pkg::PIO_REG_D_SAMPLE) ##0 sci_enabled
      |=> s_axi_rdata[pio_pkg::PD_SCI_HI:pio_pkg::PD_SCI_LO] == 2'h0)
    else $error("sci shared bits not zero");

  a_pd_unused_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_ar_take(pio_pkg::PIO_REG_D_SAMPLE) |=> s_axi_rdata[pio_pkg::PD_BIT_UNUSED] == 1'b0
      && s_axi_rresp == pio_pkg::RESP_OKAY)
    else $error("unused port d bit not zero");

  a_pullup_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && pullup_option && port_b_direction_r[0] |=> !second_port_pullup_en[0])
    else $error("pull-up on while pin drives");

  a_sync_delay: assert property (@(posedge sys_clk) disable iff (!resetn)
    ce [*3] |-> pd_sync == $past(input_port_pins_in, 2))
    else $error("pin sample delay not two cycles");

endmodule // pio_ports

`default_nettype wire

/* File: tb/pio_pin_model.sv */
/*
  board model for one 8-bit bidirectional port: block drive, external
  driver, optional pull-up. assumes the block's single clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pio_pin_model (
  // clock
  input wire logic sys_clk,
  // block side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_en,
  // board side
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  output logic [7:0] level
);
  // an undriven, unpulled pin wanders
  logic [7:0] float_r = 8'h5A;

  always_ff @(posedge sys_clk) float_r <= ~level;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) level[i] = pin_out[i];
      else if (ext_drv[i]) level[i] = ext_val[i];
      else if (pull_en[i]) level[i] = 1'b1;
      else level[i] = float_r[i];
    end
  end
endmodule // pio_pin_model

`default_nettype wire

/* File: tb/pio_ports_bench.sv */
/*
  self-checking bench for the parallel port block over axi4-lite.
  assumes pio_pin_model on every bidirectional port.
*/
`timescale 1ns/100ps
`default_nettype none

module pio_ports_bench;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] p_out [3], p_oe [3], p_lvl [3], pu_en;
  logic [7:0] ext_v [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] ext_d [3] = '{8'hFF, 8'hFF, 8'hFF};
  logic [6:0] pd_in = '0;
  logic spi = 0, sci = 0, pu_opt = 1;
  logic [31:0] seed = 32'd4835;
  int num_errors = 0;
  int n_checks = 0;

  pio_ports dut_u (.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_port_pins_in(p_lvl[0]), .first_port_pins_out(p_out[0]),
    .first_port_pins_oe(p_oe[0]), .second_port_pins_in(p_lvl[1]),
    .second_port_pins_out(p_out[1]), .second_port_pins_oe(p_oe[1]),
    .second_port_pullup_en(pu_en), .third_port_pins_in(p_lvl[2]),
    .third_port_pins_out(p_out[2]), .third_port_pins_oe(p_oe[2]),
    .input_port_pins_in(pd_in), .spi_enabled(spi), .sci_enabled(sci),
    .pullup_option(pu_opt));

  for (genvar g = 0; g < 3; g++) begin : g_pins
    pio_pin_model pin_u (.sys_clk(sys_clk), .pin_out(p_out[g]), .pin_oe(p_oe[g]),
      .pull_en((g == 1) ? pu_en : 8'h00), .ext_val(ext_v[g]), .ext_drv(ext_d[g]),
      .level(p_lvl[g]));
  end

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] exp_pin(input logic [7:0] m, l, p);
    return {24'h0, (m & l) | (~m & p)};
  endfunction

  function automatic logic [31:0] exp_pd(input logic [6:0] p, input logic s, c);
    return {24'h0, p[6], 1'b0, s ? 4'h0 : p[5:2], c ? 2'h0 : p[1:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d, output logic [1:0] rsp);
    bit aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge sys_clk);
    awaddr <= {6'h00, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge sys_clk);
    araddr <= {6'h00, idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    logic [31:0] d, t;
    logic [1:0] r;
    logic [7:0] dv, mv;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      rd(4'(p + 4), d, r);
      chk(d, 32'h0, "dir reset");
      chk(p_oe[p], 8'h00, "oe reset");
    end
    chk(pu_en, 8'hFF, "pullup reset");
    repeat (12) begin
      for (int p = 0; p < 3; p++) begin
        dv = rnd();
        mv = rnd();
        t = rnd();
        ext_v[p] <= t[15:8];
        pu_opt <= t[0];
        wr(4'(p), dv, r);
        chk(r, 32'h0, "latch write");
        wr(4'(p + 4), mv, r);
        chk(p_out[p], dv, "pin drive");
        chk(p_oe[p], mv, "pin enable");
        rd(4'(p), d, r);
        chk(d, exp_pin(mv, dv, t[15:8]), "port read");
        if (p == 1) chk(pu_en, {8{t[0]}} & ~mv, "pullup");
      end
    end
    pu_opt <= 1'b1;
    ext_d[1] <= 8'h00;
    wr(4'h1, 8'hA5, r);
    wr(4'h5, 8'h0F, r);
    // pull-up enable lags the direction write by one cycle
    @(posedge sys_clk);
    rd(4'h1, d, r);
    chk(d, 32'hF5, "pulled inputs");
    ext_d[1] <= 8'hFF;
    ext_v[1] <= 8'h3C;
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(p_out[1], 8'hA5, "latch kept");
    chk(p_oe[1], 8'h00, "dir cleared");
    rd(4'h1, d, r);
    chk(d, 32'h3C, "input after reset");
    rd(4'h2, d, r);
    chk(d, {24'h0, ext_v[2]}, "port c input");
    // clock enable low freezes the registered pull-up enable
    ce <= 1'b0;
    pu_opt <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(pu_en, 8'hFF, "frozen by ce");
    ce <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(pu_en, 8'h00, "ce released");
    pu_opt <= 1'b1;
    // strobe bit 0 low: write answered but latch kept
    wstrb <= 4'h0;
    wr(4'h1, 8'h00, r);
    chk(r, 32'h0, "strobe off write");
    wstrb <= 4'h1;
    wr(4'h5, 8'hFF, r);
    rd(4'h1, d, r);
    chk(d, 32'hA5, "output reads latch");
    for (int k = 0; k < 4; k++) begin
      t = rnd();
      pd_in <= t[6:0];
      spi <= k[1];
      sci <= k[0];
      wr(4'h3, 8'hFF, r);
      chk(r, 32'h0, "port d write");
      rd(4'h3, d, r);
      chk(d, exp_pd(t[6:0], k[1], k[0]), "port d read");
    end
    wr(4'h7, 8'h55, r);
    chk(r, pio_pkg::RESP_SLVERR, "unmapped write");
    rd(4'h7, d, r);
    chk({r, d[29:0]}, {pio_pkg::RESP_SLVERR, 30'h0}, "unmapped read");
    complete_run();
  end

  initial begin
    #400000;
    num_errors++;
    complete_run();
  end
endmodule // pio_ports_bench

`default_nettype wire
